// *** pkg/irq_bank_map.svh ***
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CONTROL     3'h0
`define OFS_ENABLE_0    3'h1
`define OFS_STATUS_0    3'h2
`define OFS_ENABLE_5    3'h3
`define OFS_ENABLE_6    3'h4
`define OFS_ENABLE_7    3'h5
`define OFS_PIN_SELECT  3'h6

// ****************************************
// implemented bits
// ****************************************
`define MASK_CONTROL    8'hc1
`define MASK_ENABLE_0   8'h31
`define MASK_STATUS_RD  8'h31
`define MASK_STATUS_CLR 8'h21
`define MASK_ENABLE_5   8'hf1
`define MASK_ENABLE_6   8'h03
`define MASK_ENABLE_7   8'h31

// ****************************************
// field positions
// ****************************************
`define BIT_GLOBAL_EN   7
`define BIT_PERIPH_EN   6
`define BIT_EDGE_SEL    0
`define BIT_TIMER0      5
`define BIT_CHANGE      4
`define BIT_EXT_PIN     0

// ****************************************
// reset values
// ****************************************
`define RESET_BYTE      8'h00

`endif

// *** pkg/irq_bank_pkg.sv ***
`default_nettype none

package irq_bank_pkg;

  // per-port change-detect flags, ports a to e
  typedef struct packed {
    logic [7:0] port_e;
    logic [7:0] port_d;
    logic [7:0] port_c;
    logic [7:0] port_b;
    logic [7:0] port_a;
  } port_change_type;

  // peripheral flag bytes for enable registers 5, 6 and 7
  typedef struct packed {
    logic [7:0] flags7;
    logic [7:0] flags6;
    logic [7:0] flags5;
  } periph_flags_type;

endpackage

`default_nettype wire

// *** hdl/ext_pin_edge.sv ***
`timescale 1ns/1ps
`default_nettype none

module ext_pin_edge (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  // pin and edge choice
  input  wire logic pin_raw,
  input  wire logic rising_sel,
  // detected edge
  output logic      edge_pulse
);

  logic       prev_q;
  logic [2:0] fill_q;

  // ****************************************
  // previous level and fill tracking
  // ****************************************
  // pin_raw arrives already synchronised; fill_q holds detection off
  // until real pin levels have reached prev_q, so reset is never an edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      fill_q <= 3'h0;
    end else if (ce) begin
      prev_q <= pin_raw;
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // ****************************************
  // edge detect
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_pulse <= 1'b0;
    end else if (ce) begin
      edge_pulse <= fill_q[2]
                    & (rising_sel ? (pin_raw & ~prev_q) : (~pin_raw & prev_q)); // R17
    end
  end

endmodule // ext_pin_edge

`default_nettype wire

// *** hdl/peripheral_irq_enable_flag_bank.sv ***
// Function
// R1 - enable 5 bits 7..4 are writable enables for logic cells 4..1
// R2 - enable 5 bit 0 enables the timer1 gate acquisition interrupt
// R3 - unimplemented bits ignore writes and read as zero
// R4 - sources of enables 1..7 also need the peripheral enable
// R5 - enable 6 bit 1 for capture/compare 2, bit 0 for unit 1
// R6 - enable 7 bit 5 enables the memory task complete interrupt
// R7 - enable 7 bit 4 enables the oscillator rollover interrupt
// R8 - enable 7 bit 0 enables the waveform generator interrupt
// R9 - all enables and writable flags clear to zero on any reset
// R10 - status bit 5 set on timer0 overflow, held until software clears
// R11 - status bit 4 reads as the or of all port change flags
// R12 - software clears the summary by clearing each port change flag
// R13 - status bit 0 set on the external pin event, software clears
// R14 - the external interrupt pin is chosen by a select register
// R15 - global enable gates every interrupt
// R16 - status-0 sources need only the global enable
// R17 - edge select: one picks rising edge, zero picks falling edge
// R18 - flags set whatever the enables say
// R19 - cpu request high while any enabled flag is pending
//
// Design decisions made here: the plain strobed port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

`include "irq_bank_map.svh"

module peripheral_irq_enable_flag_bank
  import irq_bank_pkg::*;
#(
  parameter int PIN_COUNT = 8,
  parameter int SEL_W     = 3
) (
  // clock, reset and enable
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // register port
  input  wire logic [2:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // event sources
  input  wire logic             timer0_overflow,
  input  wire port_change_type  port_change_flags,
  input  wire periph_flags_type periph_flags,
  input  wire logic [PIN_COUNT-1:0] ext_pins,
  // request to the cpu
  output logic                  cpu_irq
);

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0]       control_q;
  logic [7:0]       enable0_q;
  logic [7:0]       periph_en_q [3];
  logic [SEL_W-1:0] ext_pin_source_select;
  logic             timer0_overflow_flag;
  logic             ext_pin_irq_flag;
  logic             ext_edge;
  logic             ext_pin_raw;
  logic             change_detect_summary_flag;
  logic             global_irq_enable;
  logic             periph_irq_global_enable;
  logic             ext_pin_edge_select;
  logic [7:0]       status_view;
  logic [7:0]       rdata_d;
  logic             irq_d;
  logic             core_pending;
  logic             periph_pending;
  logic             status_clr_t0;
  logic             status_clr_ext;

  localparam logic [7:0] PERIPH_MASK [3] = '{
    `MASK_ENABLE_5,
    `MASK_ENABLE_6,
    `MASK_ENABLE_7
  };
  localparam logic [2:0] PERIPH_OFS [3] = '{
    `OFS_ENABLE_5,
    `OFS_ENABLE_6,
    `OFS_ENABLE_7
  };

  assign global_irq_enable        = control_q[`BIT_GLOBAL_EN];
  assign periph_irq_global_enable = control_q[`BIT_PERIPH_EN];
  assign ext_pin_edge_select      = control_q[`BIT_EDGE_SEL];

  // ****************************************
  // control and enable 0
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control_q <= `RESET_BYTE; // R9
    end else if (ce && reg_wr && hit(reg_addr, `OFS_CONTROL)) begin
      control_q <= reg_wdata & `MASK_CONTROL; // R3
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable0_q <= `RESET_BYTE; // R9
    end else if (ce && reg_wr && hit(reg_addr, `OFS_ENABLE_0)) begin
      enable0_q <= reg_wdata & `MASK_ENABLE_0; // R3
    end
  end

  // ****************************************
  // peripheral enables 5, 6 and 7
  // ****************************************
  for (genvar i = 0; i < 3; i++) begin : g_periph_en
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        periph_en_q[i] <= `RESET_BYTE; // R9
      end else if (ce && reg_wr && hit(reg_addr, PERIPH_OFS[i])) begin
        // R1 R2 R5 R6 R7 R8
        periph_en_q[i] <= reg_wdata & PERIPH_MASK[i]; // R3
      end
    end
  end

  // ****************************************
  // external pin source
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_pin_source_select <= '0;
    end else if (ce && reg_wr && hit(reg_addr, `OFS_PIN_SELECT)) begin
      ext_pin_source_select <= reg_wdata[SEL_W-1:0]; // R14
    end
  end

  // ****************************************
  // pin synchroniser
  // ****************************************
  // every pin is synchronised ahead of the source mux, so no logic
  // ever reads an asynchronous pin level directly
  logic [PIN_COUNT-1:0] pin_meta_q;
  logic [PIN_COUNT-1:0] pin_sync_q;

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin_sync
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pin_meta_q[p] <= 1'b0;
        pin_sync_q[p] <= 1'b0;
      end else if (ce) begin
        pin_meta_q[p] <= ext_pins[p];
        pin_sync_q[p] <= pin_meta_q[p];
      end
    end
  end

  always_comb begin
    ext_pin_raw = 1'b0;
    if (int'(ext_pin_source_select) < PIN_COUNT) begin
      ext_pin_raw = pin_sync_q[ext_pin_source_select]; // R14
    end
  end

  ext_pin_edge u_ext_pin_edge (
    .core_clk   (core_clk),
    .rst        (rst),
    .ce         (ce),
    .pin_raw    (ext_pin_raw),
    .rising_sel (ext_pin_edge_select),
    .edge_pulse (ext_edge)
  );

  // ****************************************
  // status flags
  // ****************************************
  assign status_clr_t0  = reg_wr && hit(reg_addr, `OFS_STATUS_0)
                          && reg_wdata[`BIT_TIMER0];
  assign status_clr_ext = reg_wr && hit(reg_addr, `OFS_STATUS_0)
                          && reg_wdata[`BIT_EXT_PIN];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer0_overflow_flag <= 1'b0; // R9
    end else if (ce) begin
      if (timer0_overflow) begin
        timer0_overflow_flag <= 1'b1; // R10 R18
      end else if (status_clr_t0) begin
        timer0_overflow_flag <= 1'b0; // R10
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_pin_irq_flag <= 1'b0; // R9
    end else if (ce) begin
      if (ext_edge) begin
        ext_pin_irq_flag <= 1'b1; // R13 R18
      end else if (status_clr_ext) begin
        ext_pin_irq_flag <= 1'b0; // R13
      end
    end
  end

  // summary is not stored, so writes cannot touch it
  assign change_detect_summary_flag = |port_change_flags; // R11

  always_comb begin
    status_view                = 8'h00; // R3
    status_view[`BIT_TIMER0]   = timer0_overflow_flag;
    status_view[`BIT_CHANGE]   = change_detect_summary_flag; // R11
    status_view[`BIT_EXT_PIN]  = ext_pin_irq_flag;
  end

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CONTROL:    rdata_d = control_q;
        `OFS_ENABLE_0:   rdata_d = enable0_q;
        `OFS_STATUS_0:   rdata_d = status_view;
        `OFS_ENABLE_5:   rdata_d = periph_en_q[0];
        `OFS_ENABLE_6:   rdata_d = periph_en_q[1];
        `OFS_ENABLE_7:   rdata_d = periph_en_q[2];
        `OFS_PIN_SELECT: rdata_d = 8'(ext_pin_source_select);
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= rdata_d;
    end
  end

  // ****************************************
  // interrupt request
  // ****************************************
  assign core_pending   = |(status_view & enable0_q); // R16
  assign periph_pending = |(periph_flags.flags5 & periph_en_q[0])
                        | |(periph_flags.flags6 & periph_en_q[1])
                        | |(periph_flags.flags7 & periph_en_q[2]);

  assign irq_d = global_irq_enable // R15
               & (core_pending | (periph_irq_global_enable & periph_pending)); // R4 R19

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_irq <= 1'b0;
    end else if (ce) begin
      cpu_irq <= irq_d; // R19
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence en5_write_s;
    ce && reg_wr && reg_addr == `OFS_ENABLE_5;
  endsequence

  sequence en6_write_s;
    ce && reg_wr && reg_addr == `OFS_ENABLE_6;
  endsequence

  sequence en7_write_s;
    ce && reg_wr && reg_addr == `OFS_ENABLE_7;
  endsequence

  enable5_write_a: assert property ( // R1 R2
    en5_write_s |=> periph_en_q[0] == ($past(reg_wdata) & 8'hf1))
    else $error("enable 5 did not take the written value");

  enable6_write_a: assert property ( // R5
    en6_write_s |=> periph_en_q[1] == ($past(reg_wdata) & 8'h03))
    else $error("enable 6 did not take the written value");

  enable7_write_a: assert property ( // R6 R7 R8
    en7_write_s |=> periph_en_q[2] == ($past(reg_wdata) & 8'h31))
    else $error("enable 7 did not take the written value");

  reserved_read_a: assert property ( // R3
    ce && reg_rd && reg_addr == `OFS_ENABLE_6 |=> reg_rdata[7:2] == 6'h00)
    else $error("unimplemented enable 6 bits read nonzero");

  timer0_sticky_a: assert property ( // R10
    ce && timer0_overflow |=> timer0_overflow_flag
      ##1 (timer0_overflow_flag || $past(status_clr_t0) || !$past(ce)))
    else $error("timer0 flag not set or lost without clear");

  summary_read_a: assert property ( // R11
    ce && reg_rd && reg_addr == `OFS_STATUS_0
      |=> reg_rdata[4] == $past(|port_change_flags))
    else $error("change summary does not match port flags");

  ext_flag_set_a: assert property ( // R13 R18
    ce && ext_edge |=> ext_pin_irq_flag)
    else $error("external pin flag not set after a detected edge");

  global_gate_a: assert property ( // R15
    ce && !global_irq_enable |=> !cpu_irq)
    else $error("interrupt raised with global enable low");

  core_no_periph_irq_global_enable_a: assert property ( // R16
    ce && global_irq_enable && !periph_irq_global_enable
      && core_pending |=> cpu_irq)
    else $error("status-0 source blocked by peripheral enable");

  periph_needs_periph_irq_global_enable_a: assert property ( // R4
    ce && !core_pending && !periph_irq_global_enable |=> !cpu_irq)
    else $error("peripheral interrupt without peripheral enable");

  edge_to_flag_a: assert property ( // R17
    ce && ext_pin_edge_select && $rose(ext_pin_raw) && $past(ce)
      && u_ext_pin_edge.fill_q[2]
      |=> ##1 !ce || ext_pin_irq_flag || $past(status_clr_ext))
    else $error("rising edge did not set the external flag");

  timer0_clear_a: assert property ( // R10
    ce && status_clr_t0 && !timer0_overflow |=> !timer0_overflow_flag)
    else $error("timer0 flag not cleared by a written one");

  ext_clear_a: assert property ( // R13
    ce && status_clr_ext && !ext_edge |=> !ext_pin_irq_flag)
    else $error("external pin flag not cleared by a written one");

  periph_irq_a: assert property ( // R19
    ce && global_irq_enable && periph_irq_global_enable
      && |(periph_flags.flags5 & periph_en_q[0]) |=> cpu_irq)
    else $error("enabled peripheral flag raised no request");

  unmapped_read_a: assert property ( // R3
    ce && reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");

endmodule // peripheral_irq_enable_flag_bank

`default_nettype wire

// *** dv/event_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module event_source_model
  import irq_bank_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // event lines into the flag bank
  output var logic        timer0_overflow,
  output var port_change_type  port_change_flags,
  output var periph_flags_type periph_flags,
  output var logic [7:0]  ext_pins
);
  initial begin
    timer0_overflow   = 1'b0;
    port_change_flags = '0;
    periph_flags      = '0;
    ext_pins          = 8'hff;
  end

  // ****************************************
  // event commands
  // ****************************************
  // overflow is a single-cycle pulse
  task automatic pulse_timer0();
    @(posedge core_clk);
    timer0_overflow <= 1'b1;
    @(posedge core_clk);
    timer0_overflow <= 1'b0;
  endtask

  // the summary only drops once every port flag is cleared here
  task automatic set_port(input port_change_type v);
    @(posedge core_clk);
    port_change_flags <= v;
  endtask

  task automatic set_periph(input periph_flags_type v);
    @(posedge core_clk);
    periph_flags <= v;
  endtask

  task automatic set_pin(input int i, input logic v);
    @(posedge core_clk);
    ext_pins[i] <= v;
  endtask
endmodule // event_source_model

`default_nettype wire

// *** dv/peripheral_irq_enable_flag_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "irq_bank_map.svh"

module peripheral_irq_enable_flag_bank_tb
  import irq_bank_pkg::*;
;
  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic             ce = 1'b1;
  logic [2:0]       reg_addr = 3'h0;
  logic [7:0]       reg_wdata = 8'h00;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [7:0]       reg_rdata;
  logic             cpu_irq;
  logic             timer0_overflow;
  port_change_type  port_change_flags;
  periph_flags_type periph_flags;
  logic [7:0]       ext_pins;
  logic [7:0]       rv;
  int               miscompares = 0;
  int               samples_checked = 0;

  always #4 core_clk = ~core_clk;

  peripheral_irq_enable_flag_bank dut (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer0_overflow(timer0_overflow),
    .port_change_flags(port_change_flags), .periph_flags(periph_flags),
    .ext_pins(ext_pins), .cpu_irq(cpu_irq));

  event_source_model src (
    .core_clk(core_clk), .timer0_overflow(timer0_overflow),
    .port_change_flags(port_change_flags), .periph_flags(periph_flags),
    .ext_pins(ext_pins));

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
    cmp_byte(rv, e);
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge core_clk);
    #1 cmp_bit(cpu_irq, e);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic reg_access();
    logic [2:0] a [6] = '{`OFS_CONTROL, `OFS_ENABLE_0, `OFS_ENABLE_5, `OFS_ENABLE_6,
                          `OFS_ENABLE_7, 3'h7};
    logic [7:0] m [6] = '{`MASK_CONTROL, `MASK_ENABLE_0, `MASK_ENABLE_5, `MASK_ENABLE_6,
                          `MASK_ENABLE_7, 8'h00};
    int i;
    for (i = 0; i < 6; i++) chk_reg(a[i], 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(a[i], 8'hff);
      chk_reg(a[i], m[i]);
    end
    wr(`OFS_STATUS_0, 8'hff);
    chk_reg(`OFS_STATUS_0, 8'h00);
    wr(`OFS_PIN_SELECT, 8'hff);
    chk_reg(`OFS_PIN_SELECT, 8'h07);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) chk_reg(a[i], 8'h00);
  endtask

  task automatic timer0_flag();
    src.pulse_timer0();
    chk_reg(`OFS_STATUS_0, 8'h20);
    chk_irq(1'b0);
    wr(`OFS_ENABLE_0, 8'h20);
    chk_irq(1'b0);
    wr(`OFS_CONTROL, 8'h80);
    chk_irq(1'b1);
    wr(`OFS_STATUS_0, 8'h00);
    chk_reg(`OFS_STATUS_0, 8'h20);
    wr(`OFS_STATUS_0, 8'h20);
    chk_reg(`OFS_STATUS_0, 8'h00);
    chk_irq(1'b0);
  endtask

  task automatic change_summary();
    wr(`OFS_ENABLE_0, 8'h10);
    src.set_port(40'h8001000001);
    chk_reg(`OFS_STATUS_0, 8'h10);
    chk_irq(1'b1);
    wr(`OFS_STATUS_0, 8'h10);
    chk_reg(`OFS_STATUS_0, 8'h10);
    src.set_port(40'h0000000001);
    chk_reg(`OFS_STATUS_0, 8'h10);
    src.set_port(40'h0000000000);
    chk_reg(`OFS_STATUS_0, 8'h00);
    chk_irq(1'b0);
  endtask

  task automatic periph_gating();
    logic [7:0] em [3] = '{`MASK_ENABLE_5, `MASK_ENABLE_6, `MASK_ENABLE_7};
    int r;
    int b;
    wr(`OFS_CONTROL, 8'hc0);
    wr(`OFS_ENABLE_5, 8'hff);
    wr(`OFS_ENABLE_6, 8'hff);
    wr(`OFS_ENABLE_7, 8'hff);
    for (r = 0; r < 3; r++) begin
      for (b = 0; b < 8; b++) begin
        src.set_periph(24'h000001 << (8 * r + b));
        chk_irq(em[r][b]);
      end
    end
    src.set_periph(24'h000001);
    wr(`OFS_CONTROL, 8'h80);
    chk_irq(1'b0);
    wr(`OFS_CONTROL, 8'hc0);
    chk_irq(1'b1);
    wr(`OFS_ENABLE_5, 8'h00);
    chk_irq(1'b0);
    src.set_periph(24'h000000);
  endtask

  task automatic ext_pin();
    wr(`OFS_PIN_SELECT, 8'h02);
    wr(`OFS_CONTROL, 8'h81);
    wr(`OFS_ENABLE_0, 8'h01);
    repeat (8) @(posedge core_clk);
    wr(`OFS_STATUS_0, 8'h01);
    src.set_pin(0, 1'b0);
    repeat (8) @(posedge core_clk);
    src.set_pin(0, 1'b1);
    repeat (8) @(posedge core_clk);
    chk_reg(`OFS_STATUS_0, 8'h00);
    src.set_pin(2, 1'b0);
    repeat (8) @(posedge core_clk);
    chk_reg(`OFS_STATUS_0, 8'h00);
    src.set_pin(2, 1'b1);
    repeat (8) @(posedge core_clk);
    chk_reg(`OFS_STATUS_0, 8'h01);
    chk_irq(1'b1);
    wr(`OFS_STATUS_0, 8'h01);
    chk_reg(`OFS_STATUS_0, 8'h00);
    // after edge select goes to zero and the flag is cleared, a falling edge on pin 2 sets it
    wr(`OFS_CONTROL, 8'h80);
    repeat (8) @(posedge core_clk);
    wr(`OFS_STATUS_0, 8'h01);
    src.set_pin(2, 1'b0);
    repeat (8) @(posedge core_clk);
    chk_reg(`OFS_STATUS_0, 8'h01);
  endtask

  // a write while ce is low must leave enable 6 as it was
  task automatic ce_freeze();
    @(posedge core_clk);
    ce        <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= `OFS_ENABLE_6;
    reg_wdata <= 8'h00;
    @(posedge core_clk);
    ce        <= 1'b1;
    reg_wr    <= 1'b0;
    chk_reg(`OFS_ENABLE_6, `MASK_ENABLE_6);
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #50us;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    reg_access();
    timer0_flag();
    change_summary();
    periph_gating();
    ce_freeze();
    ext_pin();
    end_of_test();
  end
endmodule // peripheral_irq_enable_flag_bank_tb

`default_nettype wire
